// ===== pkg/acl_pkg.sv
// package: constants, register map and carrier types of the acl classifier
package acl_pkg;

    // ==========================================================
    // capacity
    localparam int MAX_GROUPS = 220;
    localparam int REDUCED_GROUPS = 200;
    localparam int IDX_W = 8;
    localparam int PORT_COUNT = 10;
    localparam int STAGE_WORDS = 11;

    // ==========================================================
    // group types and field limits
    localparam logic [1:0] TYPE_IPV4 = 2'h0;
    localparam logic [1:0] TYPE_NON_IPV4 = 2'h1;
    localparam logic [1:0] TYPE_BINDING = 2'h2;
    localparam logic [11:0] VID_MIN = 12'h001;
    localparam logic [11:0] VID_MAX = 12'hFFE;
    localparam logic [3:0] PORT_ANY = 4'h0;
    localparam logic [3:0] PORT_MAX = 4'hA;

    // ==========================================================
    // preset values offered to software
    localparam logic [7:0] PROTO_ICMP = 8'h01;
    localparam logic [7:0] PROTO_IGMP = 8'h02;
    localparam logic [7:0] PROTO_TCP = 8'h06;
    localparam logic [7:0] PROTO_UDP = 8'h11;
    localparam logic [15:0] L4_FTP = 16'h0015;
    localparam logic [15:0] L4_HTTP = 16'h0050;
    localparam logic [15:0] L4_DHCP = 16'h0043;
    localparam logic [15:0] L4_TFTP = 16'h0045;
    localparam logic [15:0] L4_NETBIOS = 16'h0089;
    localparam logic [15:0] ETYPE_ARP = 16'h0806;
    localparam logic [15:0] ETYPE_IPX = 16'h8137;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_CFG = 8'h0C;
    localparam logic [7:0] REG_PROTO = 8'h10;
    localparam logic [7:0] REG_SIP = 8'h14;
    localparam logic [7:0] REG_SMASK = 8'h18;
    localparam logic [7:0] REG_DIP = 8'h1C;
    localparam logic [7:0] REG_DMASK = 8'h20;
    localparam logic [7:0] REG_L4PORT = 8'h24;
    localparam logic [7:0] REG_ETYPE = 8'h28;
    localparam logic [7:0] REG_MAC_LO = 8'h2C;
    localparam logic [7:0] REG_MAC_HI = 8'h30;
    localparam logic [7:0] REG_BIND_IP = 8'h34;
    localparam logic [7:0] REG_GRP_SEL = 8'h38;
    localparam logic [7:0] REG_GRP_STAT = 8'h3C;

    // ==========================================================
    // field positions
    localparam int CTRL_BIND_EN = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_CMD_ERR = 1;
    localparam int STAT_PERMIT = 2;
    localparam int STAT_HIT = 3;
    localparam int STAT_GROUP_LSB = 8;
    localparam int STAT_NGRP_LSB = 16;
    localparam int CFG_DENY = 0;
    localparam int CFG_VLAN_ANY = 1;
    localparam int CFG_TYPE_LSB = 2;
    localparam int CFG_SIP_ANY = 4;
    localparam int CFG_DIP_ANY = 5;
    localparam int CFG_FRAG_CHK = 6;
    localparam int CFG_PROTO_ANY = 7;
    localparam int CFG_TCP_ANY = 8;
    localparam int CFG_UDP_ANY = 9;
    localparam int CFG_ETYPE_ANY = 10;
    localparam int CFG_PORT_LSB = 12;
    localparam int CFG_VID_LSB = 16;
    localparam int CMD_OP_LSB = 8;
    localparam int ETYPE_BPORT_LSB = 16;

    // ==========================================================
    // commands
    localparam logic [2:0] CMD_ADD = 3'h1;
    localparam logic [2:0] CMD_DELETE = 3'h2;
    localparam logic [2:0] CMD_ENABLE = 3'h3;
    localparam logic [2:0] CMD_DISABLE = 3'h4;

    // ==========================================================
    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_RESET = 32'h0001_07B2;
    localparam logic [31:0] MASK_RESET = 32'hFFFF_FFFF;
    localparam logic [31:0] ETYPE_RESET = 32'h0001_0000;
    localparam logic [31:0] MAC_LO_RESET = 32'h2233_4455;
    localparam logic [31:0] MAC_HI_RESET = 32'h0000_0011;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic valid;
        logic enabled;
        logic deny;
        logic vlan_any;
        logic [11:0] vid;
        logic [1:0] gtype;
        logic sip_any;
        logic [31:0] sip;
        logic [31:0] smask;
        logic dip_any;
        logic [31:0] dip;
        logic [31:0] dmask;
        logic frag_chk;
        logic proto_any;
        logic [7:0] proto;
        logic tcp_any;
        logic [15:0] tcp_port;
        logic udp_any;
        logic [15:0] udp_port;
        logic [3:0] src_port;
        logic etype_any;
        logic [15:0] etype;
        logic [47:0] mac;
        logic [31:0] bind_ip;
        logic [3:0] bind_port;
    } acl_entry_t;

    typedef struct packed {
        logic [11:0] vid;
        logic is_ipv4;
        logic [31:0] sip;
        logic [31:0] dip;
        logic frag;
        logic [7:0] proto;
        logic [15:0] l4_dport;
        logic [15:0] etype;
        logic [47:0] smac;
        logic [3:0] in_port;
    } pkt_hdr_t;

endpackage

// ===== rtl/acl_cmd_decode.sv
// module: decodes a group command word and checks the group number
`timescale 1ns/1ps
module acl_cmd_decode #(
    parameter int NUM_GROUPS = acl_pkg::MAX_GROUPS
) (
    input wire logic [31:0] cmd_i,
    output logic [acl_pkg::IDX_W-1:0] idx_o,
    output logic ok_o,
    output logic add_o,
    output logic del_o,
    output logic ena_o,
    output logic dis_o
);

    logic [acl_pkg::IDX_W-1:0] grp;
    logic [2:0] op;
    logic in_range;

    always_comb begin
        grp = cmd_i[acl_pkg::IDX_W-1:0];
        op = cmd_i[acl_pkg::CMD_OP_LSB +: 3];
        in_range = (grp != '0) && (grp <= acl_pkg::IDX_W'(NUM_GROUPS));
        idx_o = grp - acl_pkg::IDX_W'(1);
        add_o = op == acl_pkg::CMD_ADD;
        del_o = op == acl_pkg::CMD_DELETE;
        ena_o = op == acl_pkg::CMD_ENABLE;
        dis_o = op == acl_pkg::CMD_DISABLE;
        ok_o = in_range & (add_o | del_o | ena_o | dis_o);
    end

endmodule

// ===== rtl/acl_entry_match.sv
// module: compares one stored group against a parsed packet header
`timescale 1ns/1ps
module acl_entry_match (
    input wire acl_pkg::acl_entry_t entry_i,
    input wire acl_pkg::pkt_hdr_t hdr_i,
    input wire logic bind_en_i,
    output logic hit_o
);

    function automatic logic ip_ok(input logic any, input logic [31:0] pkt,
                                   input logic [31:0] cfg,
                                   input logic [31:0] mask);
        ip_ok = any | (((pkt ^ cfg) & mask) == 32'h0000_0000);
    endfunction

    logic vlan_ok;
    logic ipv4_ok;
    logic non_ipv4_ok;
    logic bind_ok;

    always_comb begin
        vlan_ok = entry_i.vlan_any | (entry_i.vid == hdr_i.vid);
        ipv4_ok = hdr_i.is_ipv4
            & ip_ok(entry_i.sip_any, hdr_i.sip, entry_i.sip, entry_i.smask)
            & ip_ok(entry_i.dip_any, hdr_i.dip, entry_i.dip, entry_i.dmask)
            & (~entry_i.frag_chk | hdr_i.frag)
            & (entry_i.proto_any | (hdr_i.proto == entry_i.proto))
            & (entry_i.tcp_any | ((hdr_i.proto == acl_pkg::PROTO_TCP)
                & (hdr_i.l4_dport == entry_i.tcp_port)))
            & (entry_i.udp_any | ((hdr_i.proto == acl_pkg::PROTO_UDP)
                & (hdr_i.l4_dport == entry_i.udp_port)))
            & ((entry_i.src_port == acl_pkg::PORT_ANY)
                | (entry_i.src_port == hdr_i.in_port));
        non_ipv4_ok = ~hdr_i.is_ipv4
            & (entry_i.etype_any | (entry_i.etype == hdr_i.etype));
        // any vlan on a binding group stands for an untagged packet
        bind_ok = bind_en_i & hdr_i.is_ipv4
            & (hdr_i.sip == entry_i.bind_ip)
            & (hdr_i.smac == entry_i.mac)
            & (hdr_i.in_port == entry_i.bind_port)
            & (entry_i.vlan_any ? (hdr_i.vid == 12'h000)
                                : (hdr_i.vid == entry_i.vid));
        hit_o = 1'b0;
        if (entry_i.valid && entry_i.enabled) begin
            case (entry_i.gtype)
                acl_pkg::TYPE_IPV4: hit_o = vlan_ok & ipv4_ok;
                acl_pkg::TYPE_NON_IPV4: hit_o = vlan_ok & non_ipv4_ok;
                acl_pkg::TYPE_BINDING: hit_o = bind_ok;
                default: hit_o = 1'b0;
            endcase
        end
    end

endmodule

// ===== rtl/acl_packet_classifier.sv
// module: acl packet classifier with wishbone registers and group table
`timescale 1ns/1ps
module acl_packet_classifier #(
    parameter int NUM_GROUPS = acl_pkg::MAX_GROUPS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    input wire logic pkt_valid_i,
    output logic pkt_ready_o,
    input wire acl_pkg::pkt_hdr_t pkt_i,
    output logic res_valid_o,
    output logic res_permit_o,
    output logic res_hit_o,
    output logic [7:0] res_group_o
);

    // ==========================================================
    // parameter check
    if (NUM_GROUPS < 1 || NUM_GROUPS > acl_pkg::MAX_GROUPS) begin : g_bad
        $error("NUM_GROUPS must lie between 1 and 220");
    end

    localparam int IW = acl_pkg::IDX_W;
    localparam logic [IW-1:0] LAST_IDX = IW'(NUM_GROUPS - 1);

    // ==========================================================
    // helpers
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        merge = r;
    endfunction

    function automatic logic [31:0] stage_reset(input int w);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (w)
            0: r = acl_pkg::CFG_RESET;
            3: r = acl_pkg::MASK_RESET;
            5: r = acl_pkg::MASK_RESET;
            7: r = acl_pkg::ETYPE_RESET;
            8: r = acl_pkg::MAC_LO_RESET;
            9: r = acl_pkg::MAC_HI_RESET;
            default: r = 32'h0000_0000;
        endcase
        stage_reset = r;
    endfunction

    // staging words: cfg, proto, sip, smask, dip, dmask, l4, etype,
    // mac_lo, mac_hi, bind_ip
    typedef logic [31:0] stage_t [acl_pkg::STAGE_WORDS];

    function automatic acl_pkg::acl_entry_t build(input stage_t s);
        acl_pkg::acl_entry_t e;
        e.valid = 1'b1;
        e.enabled = 1'b1;
        e.deny = s[0][acl_pkg::CFG_DENY];
        e.vlan_any = s[0][acl_pkg::CFG_VLAN_ANY];
        e.vid = s[0][acl_pkg::CFG_VID_LSB +: 12];
        e.gtype = s[0][acl_pkg::CFG_TYPE_LSB +: 2];
        e.sip_any = s[0][acl_pkg::CFG_SIP_ANY];
        e.dip_any = s[0][acl_pkg::CFG_DIP_ANY];
        e.frag_chk = s[0][acl_pkg::CFG_FRAG_CHK];
        e.proto_any = s[0][acl_pkg::CFG_PROTO_ANY];
        e.tcp_any = s[0][acl_pkg::CFG_TCP_ANY];
        e.udp_any = s[0][acl_pkg::CFG_UDP_ANY];
        e.etype_any = s[0][acl_pkg::CFG_ETYPE_ANY];
        e.src_port = s[0][acl_pkg::CFG_PORT_LSB +: 4];
        e.proto = s[1][7:0];
        e.sip = s[2];
        e.smask = s[3];
        e.dip = s[4];
        e.dmask = s[5];
        e.tcp_port = s[6][15:0];
        e.udp_port = s[6][31:16];
        e.etype = s[7][15:0];
        e.bind_port = s[7][acl_pkg::ETYPE_BPORT_LSB +: 4];
        e.mac = {s[9][15:0], s[8]};
        e.bind_ip = s[10];
        build = e;
    endfunction

    // refuse entries whose vlan or port numbers lie out of range
    function automatic logic legal(input acl_pkg::acl_entry_t e);
        logic ok;
        ok = e.gtype != 2'h3;
        if (!e.vlan_any && (e.vid < acl_pkg::VID_MIN
                || e.vid > acl_pkg::VID_MAX)) begin
            ok = 1'b0;
        end
        if (e.src_port > acl_pkg::PORT_MAX) begin
            ok = 1'b0;
        end
        if (e.gtype == acl_pkg::TYPE_BINDING && (e.bind_port == 4'h0
                || e.bind_port > acl_pkg::PORT_MAX)) begin
            ok = 1'b0;
        end
        legal = ok;
    endfunction

    // ==========================================================
    // state
    typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_RESULT} scan_st_t;

    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [31:0] ctrl_q, ctrl_d;
    logic cmd_err_q, cmd_err_d;
    logic [IW-1:0] grp_sel_q, grp_sel_d;
    stage_t stage_q, stage_d;
    acl_pkg::acl_entry_t table_q [NUM_GROUPS];
    acl_pkg::acl_entry_t table_d [NUM_GROUPS];
    scan_st_t state_q, state_d;
    logic [IW-1:0] idx_q, idx_d;
    acl_pkg::pkt_hdr_t hdr_q, hdr_d;
    logic permit_q, permit_d;
    logic hit_q, hit_d;
    logic [7:0] group_q, group_d;

    logic req;
    logic wr;
    logic [IW-1:0] cmd_idx;
    logic cmd_ok, cmd_add, cmd_del, cmd_ena, cmd_dis;
    logic match_w;
    acl_pkg::acl_entry_t new_entry;
    acl_pkg::acl_entry_t sel_entry;

    acl_cmd_decode #(
        .NUM_GROUPS(NUM_GROUPS)
    ) u_cmd (
        .cmd_i(dat_i),
        .idx_o(cmd_idx),
        .ok_o(cmd_ok),
        .add_o(cmd_add),
        .del_o(cmd_del),
        .ena_o(cmd_ena),
        .dis_o(cmd_dis)
    );

    acl_entry_match u_match (
        .entry_i(table_q[idx_q]),
        .hdr_i(hdr_q),
        .bind_en_i(ctrl_q[acl_pkg::CTRL_BIND_EN]),
        .hit_o(match_w)
    );

    assign req = cyc_i & stb_i & ~ack_q;
    assign wr = req & we_i;
    assign new_entry = build(stage_q);
    assign sel_entry = table_q[grp_sel_q];

    // ==========================================================
    // register bus and group table
    always_comb begin
        ack_d = req;
        rdat_d = rdat_q;
        ctrl_d = ctrl_q;
        cmd_err_d = cmd_err_q;
        grp_sel_d = grp_sel_q;
        stage_d = stage_q;
        table_d = table_q;
        if (req && !we_i) begin
            rdat_d = 32'h0000_0000;
            if (adr_i == acl_pkg::REG_CTRL) begin
                rdat_d = ctrl_q;
            end else if (adr_i == acl_pkg::REG_STATUS) begin
                rdat_d[acl_pkg::STAT_BUSY] = state_q != ST_IDLE;
                rdat_d[acl_pkg::STAT_CMD_ERR] = cmd_err_q;
                rdat_d[acl_pkg::STAT_PERMIT] = permit_q;
                rdat_d[acl_pkg::STAT_HIT] = hit_q;
                rdat_d[acl_pkg::STAT_GROUP_LSB +: 8] = group_q;
                rdat_d[acl_pkg::STAT_NGRP_LSB +: 8] = 8'(NUM_GROUPS);
            end else if (adr_i >= acl_pkg::REG_CFG
                    && adr_i <= acl_pkg::REG_BIND_IP
                    && adr_i[1:0] == 2'h0) begin
                rdat_d = stage_q[4'(6'(adr_i[7:2]) - 6'h03)];
            end else if (adr_i == acl_pkg::REG_GRP_SEL) begin
                rdat_d[IW-1:0] = grp_sel_q + IW'(1);
            end else if (adr_i == acl_pkg::REG_GRP_STAT) begin
                rdat_d[0] = sel_entry.valid;
                rdat_d[1] = sel_entry.enabled;
                rdat_d[2] = sel_entry.deny;
                rdat_d[5:4] = sel_entry.gtype;
            end
        end
        if (wr) begin
            if (adr_i == acl_pkg::REG_CTRL) begin
                ctrl_d = merge(ctrl_q, dat_i, sel_i)
                    & (32'h0000_0001 << acl_pkg::CTRL_BIND_EN);
            end else if (adr_i == acl_pkg::REG_CMD) begin
                if (!cmd_ok || (cmd_add && !legal(new_entry))
                        || ((cmd_ena || cmd_dis)
                        && !table_q[cmd_idx].valid)) begin
                    cmd_err_d = 1'b1;
                end else if (cmd_add) begin
                    table_d[cmd_idx] = new_entry;
                end else if (cmd_del) begin
                    table_d[cmd_idx].valid = 1'b0;
                end else begin
                    table_d[cmd_idx].enabled = cmd_ena;
                end
            end else if (adr_i == acl_pkg::REG_STATUS) begin
                // one bus access per cycle, so no set can collide here
                if (sel_i[0] && dat_i[acl_pkg::STAT_CMD_ERR]) begin
                    cmd_err_d = 1'b0;
                end
            end else if (adr_i >= acl_pkg::REG_CFG
                    && adr_i <= acl_pkg::REG_BIND_IP
                    && adr_i[1:0] == 2'h0) begin
                stage_d[4'(6'(adr_i[7:2]) - 6'h03)] = merge(
                    stage_q[4'(6'(adr_i[7:2]) - 6'h03)], dat_i, sel_i);
            end else if (adr_i == acl_pkg::REG_GRP_SEL) begin
                if (dat_i[IW-1:0] != '0
                        && dat_i[IW-1:0] <= IW'(NUM_GROUPS)) begin
                    grp_sel_d = dat_i[IW-1:0] - IW'(1);
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            ctrl_q <= acl_pkg::CTRL_RESET;
            cmd_err_q <= 1'b0;
            grp_sel_q <= '0;
            for (int w = 0; w < acl_pkg::STAGE_WORDS; w++) begin
                stage_q[w] <= stage_reset(w);
            end
            for (int g = 0; g < NUM_GROUPS; g++) begin
                table_q[g] <= '0;
            end
        end else begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            ctrl_q <= ctrl_d;
            cmd_err_q <= cmd_err_d;
            grp_sel_q <= grp_sel_d;
            stage_q <= stage_d;
            table_q <= table_d;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rdat_q;

    // ==========================================================
    // classification scan, one group per cycle
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        hdr_d = hdr_q;
        permit_d = permit_q;
        hit_d = hit_q;
        group_d = group_q;
        case (state_q)
            ST_IDLE: begin
                if (pkt_valid_i) begin
                    hdr_d = pkt_i;
                    idx_d = '0;
                    state_d = ST_SCAN;
                end
            end
            ST_SCAN: begin
                if (match_w) begin
                    permit_d = ~table_q[idx_q].deny;
                    hit_d = 1'b1;
                    group_d = 8'(idx_q) + 8'h01;
                    state_d = ST_RESULT;
                end else if (idx_q == LAST_IDX) begin
                    permit_d = 1'b1;
                    hit_d = 1'b0;
                    group_d = 8'h00;
                    state_d = ST_RESULT;
                end else begin
                    idx_d = idx_q + IW'(1);
                end
            end
            ST_RESULT: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            idx_q <= '0;
            hdr_q <= '0;
            permit_q <= 1'b1;
            hit_q <= 1'b0;
            group_q <= 8'h00;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            hdr_q <= hdr_d;
            permit_q <= permit_d;
            hit_q <= hit_d;
            group_q <= group_d;
        end
    end

    // table edits during a scan take effect on groups not yet visited
    assign pkt_ready_o = state_q == ST_IDLE;
    assign res_valid_o = state_q == ST_RESULT;
    assign res_permit_o = permit_q;
    assign res_hit_o = hit_q;
    assign res_group_o = group_q;

endmodule

// ===== testbench/acl_chk.sv
// checker: port-level properties of the acl classifier
`timescale 1ns/1ps
module acl_chk #(
    parameter int NUM_GROUPS = 220
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic pkt_valid_i,
    input wire logic pkt_ready_o,
    input wire logic res_valid_o,
    input wire logic res_permit_o,
    input wire logic res_hit_o,
    input wire logic [7:0] res_group_o
);
    // ====
    // properties
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    AST_ACK_NEXT:
        assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus cycle not answered");
    AST_ACK_PULSE:
        assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    AST_SCAN_BUSY:
        assert property (pkt_valid_i && pkt_ready_o |=>
            !pkt_ready_o until_with res_valid_o)
        else $error("header taken during scan");
    // worst case: every group scanned, then the miss result
    AST_SCAN_BOUND:
        assert property (pkt_valid_i && pkt_ready_o |->
            ##[2:222] res_valid_o)
        else $error("no result in time");
    AST_MISS_FWD:
        assert property (res_valid_o && !res_hit_o |->
            res_permit_o && res_group_o == 8'h00)
        else $error("miss not forwarded");
    AST_HIT_RANGE:
        assert property (res_valid_o && res_hit_o |->
            res_group_o != 8'h00 && res_group_o <= NUM_GROUPS)
        else $error("hit group out of range");
    AST_RES_HOLD:
        assert property (!res_valid_o |->
            $stable(res_permit_o) && $stable(res_group_o))
        else $error("result changed between results");
    AST_READY_BACK:
        assert property (res_valid_o |=> pkt_ready_o)
        else $error("not ready after result");
endmodule

bind acl_packet_classifier acl_chk #(.NUM_GROUPS(NUM_GROUPS)) i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .pkt_valid_i(pkt_valid_i), .pkt_ready_o(pkt_ready_o),
    .res_valid_o(res_valid_o), .res_permit_o(res_permit_o),
    .res_hit_o(res_hit_o), .res_group_o(res_group_o)
);

// ===== testbench/acl_pipe_model.sv
// partner model: forwarding pipeline offering parsed headers
`timescale 1ns/1ps
module acl_pipe_model (
    input wire logic clk_i,
    input wire logic pkt_ready_i,
    input wire logic res_valid_i,
    output logic pkt_valid_o,
    output acl_pkg::pkt_hdr_t pkt_o
);
    // ====
    // header offer
    initial begin
        pkt_valid_o = 1'b0;
        pkt_o = '0;
    end
    task automatic send(input acl_pkg::pkt_hdr_t h, input int gap);
        repeat (gap) @(posedge clk_i);
        pkt_valid_o <= 1'b1;
        pkt_o <= h;
        do @(posedge clk_i); while (pkt_ready_i !== 1'b1);
        pkt_valid_o <= 1'b0;
        // released header must not look like a stale valid one
        pkt_o <= ~h;
        do @(posedge clk_i); while (res_valid_i !== 1'b1);
    endtask
endmodule

// ===== testbench/test_acl_packet_classifier.sv
// testbench: register and packet scenarios for the acl classifier
`timescale 1ns/1ps
module test_acl_packet_classifier;
    logic clk, rst, cyc, stb, we, ack, pv, pr, rsv, rp, rh;
    logic [7:0] adr, rg;
    logic [31:0] dat, rdat, q;
    acl_pkg::pkt_hdr_t ph;
    int fail_count = 0;
    int samples_checked = 0;
    int np = 0;
    logic [7:0] ra [8] = '{8'h0C, 8'h18, 8'h20, 8'h28, 8'h2C, 8'h30,
        8'h34, 8'hFC};
    logic [31:0] rx [8] = '{acl_pkg::CFG_RESET, acl_pkg::MASK_RESET,
        acl_pkg::MASK_RESET, acl_pkg::ETYPE_RESET, acl_pkg::MAC_LO_RESET,
        acl_pkg::MAC_HI_RESET, 32'h0, 32'h0};
    // g3 ipv4 deny sip/mask tcp 80, g2 non-ipv4 vid 5 arp,
    // g1 any from port 4, g4 binding deny, then group 221
    logic [39:0] prog [15] = '{40'h0C_0000_0623, 40'h10_0000_0006,
        40'h14_C0A8_0100, 40'h18_FFFF_FF00, 40'h24_0000_0050,
        40'h04_0000_0103, 40'h0C_0005_0004, 40'h28_0001_0806,
        40'h04_0000_0102, 40'h0C_0001_47B2, 40'h04_0000_0101,
        40'h0C_0000_000B, 40'h34_0A00_0001, 40'h04_0000_0104,
        40'h04_0000_01DD};
    // disable, enable, delete group 3, each followed by the same packet
    logic [31:0] ops [3] = '{32'h0000_0403, 32'h0000_0303, 32'h0000_0203};
    logic [9:0] oe [3] = '{10'h200, 10'h103, 10'h200};

    acl_packet_classifier i_dut (
        .clk_i(clk), .rst_i(rst), .adr_i(adr), .dat_i(dat), .dat_o(rdat),
        .we_i(we), .sel_i(4'hF), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
        .pkt_valid_i(pv), .pkt_ready_o(pr), .pkt_i(ph), .res_valid_o(rsv),
        .res_permit_o(rp), .res_hit_o(rh), .res_group_o(rg)
    );
    acl_pipe_model i_pipe (
        .clk_i(clk), .pkt_ready_i(pr), .res_valid_i(rsv),
        .pkt_valid_o(pv), .pkt_o(ph)
    );

    // ====
    // tasks
    task automatic chk(input string n, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [39:0] c);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        {adr, dat} <= c;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 64);
        q = rdat;
        chk("ack", 32'h1, {31'h0, ack});
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    // expected as {permit, hit, group}
    task automatic pk(input logic [11:0] v, input logic i4,
        input logic [31:0] s, input logic [15:0] d, input logic [3:0] p,
        input logic [9:0] e);
        acl_pkg::pkt_hdr_t h;
        h = '{vid:v, is_ipv4:i4, sip:s, dip:32'h0, frag:1'b0,
            proto:acl_pkg::PROTO_TCP, l4_dport:d,
            etype:(i4 ? 16'h0800 : acl_pkg::ETYPE_ARP),
            smac:48'h0011_2233_4455, in_port:p};
        i_pipe.send(h, np % 3);
        np++;
        chk("res", {22'h0, e}, {22'h0, rp, rh, rg});
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ====
    // sequence
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        finish_test();
    end
    initial begin
        rst = 1'b1;
        {cyc, stb, we, adr, dat} = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (ra[i]) begin
            wb(1'b0, {ra[i], 32'h0});
            chk("reg", rx[i], q);
        end
        pk(12'h0, 1'b1, 32'hC0A8_01AB, 16'h50, 4'h5, 10'h200);
        foreach (prog[i]) wb(1'b1, prog[i]);
        wb(1'b0, {8'h08, 32'h0});
        chk("stat", 32'h00DC_0002, q & 32'h00FF_0002);
        pk(12'h0, 1'b1, 32'hC0A8_01AB, 16'h50, 4'h5, 10'h103);
        pk(12'h0, 1'b1, 32'hC0A8_01AB, 16'h51, 4'h5, 10'h200);
        pk(12'h0, 1'b1, 32'hC0A8_02AB, 16'h50, 4'h5, 10'h200);
        pk(12'h0, 1'b1, 32'hC0A8_01AB, 16'h50, 4'h4, 10'h301);
        pk(12'h5, 1'b0, 32'h0, 16'h0, 4'h5, 10'h302);
        pk(12'h6, 1'b0, 32'h0, 16'h0, 4'h5, 10'h200);
        pk(12'h0, 1'b1, 32'h0A00_0001, 16'h0, 4'h1, 10'h200);
        wb(1'b1, {8'h00, 32'h1});
        pk(12'h0, 1'b1, 32'h0A00_0001, 16'h0, 4'h1, 10'h104);
        pk(12'h0, 1'b1, 32'h0A00_0001, 16'h0, 4'h2, 10'h200);
        // clear the command error, then read the last miss back
        wb(1'b1, {8'h08, 32'h2});
        wb(1'b0, {8'h08, 32'h0});
        chk("stat", 32'h00DC_0004, q & 32'h00FF_FF0F);
        wb(1'b1, {8'h38, 32'h4});
        wb(1'b0, {8'h3C, 32'h0});
        chk("grp", 32'h27, q);
        foreach (ops[i]) begin
            wb(1'b1, {8'h04, ops[i]});
            pk(12'h0, 1'b1, 32'hC0A8_01AB, 16'h50, 4'h5, oe[i]);
        end
        finish_test();
    end
endmodule
